// >>> spi_pkg.sv
// shared constants and carrier types for the serial port block
package spi_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'ha2;
    localparam logic [7:0] ADDR_DATA_BUFFER   = 8'ha3;

    // values after reset
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;

    // frame layout
    localparam int         BITS_PER_FRAME = 8;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    localparam logic [3:0] LAST_HALF_TICK = 4'hf;

    // slave timing in core clock periods
    localparam int         SLAVE_OUT_MAX_CYC  = 4;
    localparam int         SLAVE_LAST_MIN_CYC = 6;
    localparam int         SLAVE_LAST_MAX_CYC = 8;
    // hold count loaded at the last edge; output moves on the edge where it counts down to zero
    localparam logic [2:0] SLAVE_LAST_HOLD = 3'(SLAVE_LAST_MIN_CYC);

    // one core clock access on the special function register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // control bits of the port that the data path needs
    typedef struct packed {
        logic enable;
        logic master;
        logic clock_polarity_sel;
        logic clock_phase_sel;
    } spi_cfg_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'b01,
        MST_XFER = 2'b10
    } master_state_t;

endpackage

// >>> spi_clock_gen.sv
// master serial clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none

module spi_clock_gen #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divide,
    // half period marker
    output logic                  half_tick
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    // one tick every divide+1 cycles gives core_clock / (2 * (divide + 1))
    always_comb
    begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run)
        begin
            cnt_d = '0;
        end
        else if (cnt_q == divide) // RULE_01
        begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign half_tick = tick_q;

endmodule // spi_clock_gen

`default_nettype wire

// >>> spi_clock_data_timing.sv
// serial port clock divider, data buffers and shift engine
// Contract
// RULE_01 - master clock is core clock over 2(div+1)
// RULE_02 - data write loads buffer, starts master transfer
// RULE_03 - data read returns receive buffer
// RULE_04 - polarity one inverts the serial clock
// RULE_05 - master waits two cycles after select falls; the master ignores slave_select_n and starts on the data write
// RULE_06 - select held two cycles after last edge; the block has no select output to hold
// RULE_07 - slave output valid four cycles after select
// RULE_08 - slave output released four cycles after select
// RULE_09 - master gives input two cycles setup, hold
// RULE_10 - slave output updates four cycles after shift
// RULE_11 - phase one: output changes 6-8 after last
// RULE_12 - done flag set per transfer, software clears
// RULE_13 - write while buffer full discarded, collision flagged
// RULE_14 - buffer empty clears on write, sets on move
// RULE_15 - divider and data reset zero, always accessible
`timescale 1ns/1ps
`default_nettype none

module spi_clock_data_timing
    import spi_pkg::*;
(
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    // special function register port
    input  wire spi_pkg::sfr_req_t sfr_req,
    output logic [7:0]           sfr_rdata,
    // configuration and flag control
    input  wire spi_pkg::spi_cfg_t cfg,
    input  wire logic            clear_done,
    input  wire logic            clear_collision,
    output logic                 transfer_done_flag,
    output logic                 write_collision_flag,
    output logic                 tx_buffer_empty,
    // serial pins
    input  wire logic            slave_select_n,
    input  wire logic            sck_in,
    output logic                 sck_out,
    output logic                 sck_oe,
    input  wire logic            mosi_in,
    output logic                 mosi_out,
    output logic                 mosi_oe,
    input  wire logic            miso_in,
    output logic                 miso_out,
    output logic                 miso_oe
);

    import spi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    master_state_t state_q,  state_d;
    logic [7:0]    div_q,    div_d;
    logic [7:0]    tx_buf_q, tx_buf_d;
    logic [7:0]    rx_buf_q, rx_buf_d;
    logic [7:0]    shift_q,  shift_d;
    logic [7:0]    rdata_q,  rdata_d;
    logic [3:0]    half_q,   half_d;
    logic [2:0]    bit_q,    bit_d;
    logic [2:0]    hold_q,   hold_d;
    logic          cap_q,    cap_d;
    logic          out_q,    out_d;
    logic          done_q,   done_d;
    logic          write_collision_flag_q,   write_collision_flag_d;
    logic          tx_buffer_empty_q,  tx_buffer_empty_d;
    logic          sck_q,    sck_d;
    logic          sck_prev_q, sck_prev_d;
    logic          ss_prev_q,  ss_prev_d;
    logic          m_oe_q,   m_oe_d;
    logic          s_oe_q,   s_oe_d;

    logic          half_tick;
    logic          master_mode;
    logic          slave_mode;
    logic          in_bit;
    logic          sck_lvl;
    logic          lead;
    logic          trail;
    logic          sample_e;
    logic          shift_e;
    logic          ss_fall;
    logic          wr_data;
    logic [7:0]    rx_byte;

    spi_clock_gen #(
        .DIV_W (8)
    ) u_clock_gen (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .run       (state_q == MST_XFER),
        .divide    (div_q),
        .half_tick (half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edge decode and next state

    always_comb
    begin
        master_mode = cfg.enable & cfg.master;
        slave_mode  = cfg.enable & ~cfg.master;
        in_bit      = master_mode ? miso_in : mosi_in;
        // link inputs are synchronous, so the pin is compared directly with its last value
        sck_lvl     = sck_in ^ cfg.clock_polarity_sel;
        ss_fall     = slave_mode & ss_prev_q & ~slave_select_n;
        lead        = master_mode ? (half_tick & ~half_q[0] & (state_q == MST_XFER))
                                  : (slave_mode & ~slave_select_n & sck_lvl & ~sck_prev_q);
        trail       = master_mode ? (half_tick & half_q[0] & (state_q == MST_XFER))
                                  : (slave_mode & ~slave_select_n & ~sck_lvl & sck_prev_q);
        sample_e    = cfg.clock_phase_sel ? trail : lead;
        shift_e     = cfg.clock_phase_sel ? lead : trail;
        rx_byte     = cfg.clock_phase_sel ? {shift_q[6:0], in_bit} : {shift_q[6:0], cap_q};
        wr_data     = sfr_req.wr & (sfr_req.addr == ADDR_DATA_BUFFER);

        state_d    = state_q;
        div_d      = div_q;
        tx_buf_d   = tx_buf_q;
        rx_buf_d   = rx_buf_q;
        shift_d    = shift_q;
        half_d     = half_q;
        bit_d      = bit_q;
        hold_d     = hold_q;
        cap_d      = cap_q;
        out_d      = out_q;
        done_d     = done_q & ~clear_done;
        write_collision_flag_d     = write_collision_flag_q & ~clear_collision;
        tx_buffer_empty_d    = tx_buffer_empty_q;
        sck_d      = sck_q;
        sck_prev_d = sck_lvl;
        ss_prev_d  = slave_select_n;
        m_oe_d     = master_mode;
        s_oe_d     = slave_mode & ~slave_select_n; // RULE_07 RULE_08
        rdata_d    = rdata_q;

        // register port; both registers stay writable in any mode
        if (sfr_req.wr && sfr_req.addr == ADDR_CLOCK_DIVIDER)
        begin
            div_d = sfr_req.wdata; // RULE_15
        end
        if (wr_data)
        begin
            if (tx_buffer_empty_q)
            begin
                tx_buf_d = sfr_req.wdata; // RULE_02
                tx_buffer_empty_d  = 1'b0;          // RULE_14
            end
            else
            begin
                write_collision_flag_d = 1'b1; // RULE_13
            end
        end
        if (sfr_req.rd)
        begin
            unique case (sfr_req.addr)
                ADDR_CLOCK_DIVIDER: rdata_d = div_q;
                ADDR_DATA_BUFFER:   rdata_d = rx_buf_q; // RULE_03
                default:            rdata_d = 8'h00;
            endcase
        end

        // master sequencing
        unique case (state_q)
            MST_IDLE:
            begin
                sck_d  = cfg.clock_polarity_sel; // RULE_04
                half_d = 4'h0;
                bit_d  = master_mode ? 3'h0 : bit_q;
                if (master_mode && !tx_buffer_empty_q)
                begin
                    shift_d = tx_buf_q; // RULE_02
                    out_d   = tx_buf_q[7];
                    tx_buffer_empty_d = 1'b1;     // RULE_14
                    state_d = MST_XFER;
                end
            end
            MST_XFER:
            begin
                if (half_tick)
                begin
                    sck_d  = ~sck_q; // RULE_04
                    half_d = half_q + 4'h1;
                    if (half_q == LAST_HALF_TICK)
                    begin
                        state_d = MST_IDLE;
                    end
                end
                if (!master_mode)
                begin
                    state_d = MST_IDLE;
                end
            end
        endcase

        // slave frame start: first bit is placed as soon as select falls
        if (ss_fall)
        begin
            bit_d  = 3'h0;
            hold_d = 3'h0;
            if (!tx_buffer_empty_q)
            begin
                shift_d = tx_buf_q;
                tx_buffer_empty_d = 1'b1; // RULE_14
                out_d   = tx_buf_q[7]; // RULE_07
            end
            else
            begin
                out_d = shift_q[7];
            end
        end

        // shared shift engine for both modes
        if (sample_e)
        begin
            cap_d = in_bit;
            if (cfg.clock_phase_sel)
            begin
                shift_d = {shift_q[6:0], in_bit};
            end
        end
        if (shift_e)
        begin
            if (cfg.clock_phase_sel)
            begin
                out_d = shift_q[7]; // RULE_10
            end
            else
            begin
                shift_d = {shift_q[6:0], cap_q};
                out_d   = shift_q[6]; // RULE_10
            end
        end
        if (trail)
        begin
            bit_d = bit_q + 3'h1;
            if (bit_q == LAST_BIT_INDEX)
            begin
                rx_buf_d = rx_byte;
                done_d   = 1'b1; // RULE_12
                shift_d  = rx_byte;
                if (slave_mode && !tx_buffer_empty_q)
                begin
                    shift_d = tx_buf_q;
                    tx_buffer_empty_d = 1'b1; // RULE_14
                end
                if (slave_mode && cfg.clock_phase_sel)
                begin
                    hold_d = SLAVE_LAST_HOLD; // RULE_11
                end
                else if (slave_mode)
                begin
                    out_d = shift_d[7];
                end
            end
        end

        // phase one: the next frame's first bit appears 7 cycles after the last edge
        if (hold_q != 3'h0)
        begin
            hold_d = hold_q - 3'h1;
            if (hold_q == 3'h1)
            begin
                out_d = shift_q[7]; // RULE_11
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q    <= MST_IDLE;
            div_q      <= DIVIDER_RESET; // RULE_15
            tx_buf_q   <= DATA_RESET;    // RULE_15
            rx_buf_q   <= DATA_RESET;    // RULE_15
            shift_q    <= 8'h00;
            rdata_q    <= 8'h00;
            half_q     <= 4'h0;
            bit_q      <= 3'h0;
            hold_q     <= 3'h0;
            cap_q      <= 1'b0;
            out_q      <= 1'b0;
            done_q     <= 1'b0;
            write_collision_flag_q     <= 1'b0;
            tx_buffer_empty_q    <= 1'b1;
            sck_q      <= 1'b0;
            sck_prev_q <= 1'b0;
            ss_prev_q  <= 1'b1;
            m_oe_q     <= 1'b0;
            s_oe_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            div_q      <= div_d;
            tx_buf_q   <= tx_buf_d;
            rx_buf_q   <= rx_buf_d;
            shift_q    <= shift_d;
            rdata_q    <= rdata_d;
            half_q     <= half_d;
            bit_q      <= bit_d;
            hold_q     <= hold_d;
            cap_q      <= cap_d;
            out_q      <= out_d;
            done_q     <= done_d;
            write_collision_flag_q     <= write_collision_flag_d;
            tx_buffer_empty_q    <= tx_buffer_empty_d;
            sck_q      <= sck_d;
            sck_prev_q <= sck_prev_d;
            ss_prev_q  <= ss_prev_d;
            m_oe_q     <= m_oe_d;
            s_oe_q     <= s_oe_d;
        end
    end

    assign sfr_rdata            = rdata_q;
    assign transfer_done_flag   = done_q;
    assign write_collision_flag = write_collision_flag_q;
    assign tx_buffer_empty      = tx_buffer_empty_q;
    assign sck_out              = sck_q;
    assign sck_oe               = m_oe_q;
    assign mosi_out             = out_q;
    assign mosi_oe              = m_oe_q;
    assign miso_out             = out_q;
    assign miso_oe              = s_oe_q;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    logic [8:0] gap_q;
    logic       seen_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gap_q  <= 9'h000;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= half_tick ? 9'h000 : gap_q + 9'h001;
            seen_q <= (state_q == MST_XFER) & (seen_q | half_tick);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_accept;
        wr_data && tx_buffer_empty_q;
    endsequence

    sequence s_master_start;
        s_accept ##0 master_mode && state_q == MST_IDLE;
    endsequence

    property p_half_period;
        half_tick && seen_q && $stable(div_q) |-> gap_q == {1'b0, div_q};
    endproperty
    a_half_period: assert property (p_half_period) else $error("half period wrong"); // RULE_01

    property p_write_loads;
        s_accept |=> tx_buf_q == $past(sfr_req.wdata) && !tx_buffer_empty;
    endproperty
    a_write_loads: assert property (p_write_loads) else $error("write not loaded"); // RULE_14

    property p_master_start;
        s_master_start |-> ##[1:2] state_q == MST_XFER;
    endproperty
    a_master_start: assert property (p_master_start) else $error("no transfer start"); // RULE_02

    property p_read_rx;
        sfr_req.rd && sfr_req.addr == ADDR_DATA_BUFFER |=> sfr_rdata == $past(rx_buf_q);
    endproperty
    a_read_rx: assert property (p_read_rx) else $error("read not receive buffer"); // RULE_03

    property p_idle_pol;
        state_q == MST_IDLE && $past(state_q) == MST_IDLE && $stable(cfg)
            |-> sck_out == cfg.clock_polarity_sel;
    endproperty
    a_idle_pol: assert property (p_idle_pol) else $error("idle clock level wrong"); // RULE_04

    property p_out_on;
        slave_mode && $fell(slave_select_n) ##0 $stable(cfg) |-> ##[1:4] miso_oe;
    endproperty
    a_out_on: assert property (p_out_on) else $error("slave output late"); // RULE_07

    property p_out_off;
        $rose(slave_select_n) |-> ##[1:4] !miso_oe;
    endproperty
    a_out_off: assert property (p_out_off) else $error("slave output not released"); // RULE_08

    property p_shift_update;
        slave_mode && shift_e && !cfg.clock_phase_sel && !(trail && bit_q == LAST_BIT_INDEX)
            |=> miso_out == $past(shift_q[6]);
    endproperty
    a_shift_update: assert property (p_shift_update) else $error("output not updated"); // RULE_10

    property p_last_hold;
        slave_mode && cfg.clock_phase_sel && trail && bit_q == LAST_BIT_INDEX && !ss_fall
            |=> $stable(miso_out) [*6];
    endproperty
    a_last_hold: assert property (p_last_hold) else $error("output moved too early"); // RULE_11

    property p_done_set;
        trail && bit_q == LAST_BIT_INDEX |=> transfer_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set"); // RULE_12

    property p_collision;
        wr_data && !tx_buffer_empty_q |=> write_collision_flag && tx_buf_q == $past(tx_buf_q);
    endproperty
    a_collision: assert property (p_collision) else $error("collision not handled"); // RULE_13

endmodule // spi_clock_data_timing

`default_nettype wire

// >>> spi_far_slave.sv
// behavioural serial slave on the far side of the master link
`timescale 1ns/1ps
`default_nettype none

module spi_far_slave
(
    // control
    input  wire logic       load,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    // link
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] tx_q;
    logic [2:0] n_q;

    // edges are taken from the wire itself, so a zero divider is answered in time
    always @(sck or posedge load)
    begin
        if (load)
        begin
            tx_q    <= tx_byte;
            n_q     <= 3'h0;
            rx_byte <= 8'h00;
        end
        else if ((sck != cpol) == cpha)
            n_q <= n_q + 3'h1;
        else
            rx_byte <= {rx_byte[6:0], mosi};
    end

    // phase one shifts on the leading edge, so the first bit shows after it
    assign miso = tx_q[~(cpha ? n_q - 3'h1 : n_q)];
endmodule // spi_far_slave
`default_nettype wire

// >>> test_spi_clock_data_timing.sv
// self-checking bench for the serial port clock and data block
`timescale 1ns/1ps
`default_nettype none

module test_spi_clock_data_timing;
    import spi_pkg::*;
    typedef struct packed {logic [7:0] div, tx, far; logic pol, pha;} row_t;
    logic       clk_sys = 0, rst_n = 0, clear_done = 0, clear_collision = 0;
    logic       slave_select_n = 1, sck_in = 0, mosi_in = 0, load = 1;
    logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
    logic       transfer_done_flag, write_collision_flag, tx_buffer_empty;
    logic [7:0] sfr_rdata, far_tx = 8'h00, far_rx, exp_half = 8'h01, mb, st;
    logic       sck_last = 0;
    sfr_req_t   sfr_req = '0;
    spi_cfg_t   cfg = '0;
    int         failures = 0, n_tests = 0, cyc = 0, t_last = 0, togs = 0, k;
    row_t       r;
    row_t       rows [4] = '{'{8'h00, 8'ha5, 8'h3c, 1'b0, 1'b0},
                             '{8'h01, 8'h81, 8'h7e, 1'b1, 1'b0},
                             '{8'h03, 8'h5a, 8'hc3, 1'b0, 1'b1},
                             '{8'h02, 8'hff, 8'h00, 1'b1, 1'b1}};

    spi_clock_data_timing dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .cfg(cfg), .clear_done(clear_done),
        .clear_collision(clear_collision), .transfer_done_flag(transfer_done_flag),
        .write_collision_flag(write_collision_flag), .tx_buffer_empty(tx_buffer_empty),
        .slave_select_n(slave_select_n), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe));
    spi_far_slave far (.load(load), .cpol(cfg.clock_polarity_sel),
        .cpha(cfg.clock_phase_sel), .tx_byte(far_tx), .sck(sck_out), .mosi(mosi_out),
        .miso(miso_in), .rx_byte(far_rx));

    always #20 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one access, strobe held for exactly one taking edge
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) sfr_req <= '{wr, ~wr, a, d};
        @(posedge clk_sys) sfr_req <= '0;
        #1;
    endtask

    task automatic wait_done();
        k = 0;
        while (transfer_done_flag !== 1'b1 && k < 2000)
        begin
            tick(1);
            k++;
        end
        // the monitor counts the last toggle one edge after the flag rises
        tick(1);
    endtask

    task automatic clr_done();
        @(posedge clk_sys) clear_done <= 1'b1;
        @(posedge clk_sys) clear_done <= 1'b0;
        tick(1);
        check(transfer_done_flag, 1'b0);
        // polarity changes between frames are not half periods
        togs = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // timeout and half-period monitor on the master clock
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            stop_test();
        end
    end

    always @(posedge clk_sys)
    begin
        if (sck_out !== sck_last)
        begin
            if (togs != 0)
                check(8'(cyc - t_last), exp_half);
            togs   = togs + 1;
            t_last = cyc;
        end
        sck_last <= sck_out;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(11);
        @(posedge clk_sys) rst_n <= 1'b1;
        load <= 1'b0;
        sfr(1'b0, ADDR_CLOCK_DIVIDER, 8'h00);
        check(sfr_rdata, DIVIDER_RESET);
        sfr(1'b0, ADDR_DATA_BUFFER, 8'h00);
        check(sfr_rdata, DATA_RESET);
        check(tx_buffer_empty, 1'b1);
        sfr(1'b1, ADDR_CLOCK_DIVIDER, 8'hff);
        sfr(1'b0, ADDR_CLOCK_DIVIDER, 8'h00);
        check(sfr_rdata, 8'hff);
        foreach (rows[i])
        begin
            r = rows[i];
            sfr(1'b1, ADDR_CLOCK_DIVIDER, r.div);
            @(posedge clk_sys) cfg <= '{1'b1, 1'b1, r.pol, r.pha};
            far_tx <= r.far;
            tick(3);
            @(posedge clk_sys) load <= 1'b1;
            @(posedge clk_sys) load <= 1'b0;
            exp_half = r.div + 8'h01;
            togs = 0;
            sfr(1'b1, ADDR_DATA_BUFFER, r.tx);
            check(tx_buffer_empty, 1'b0);
            wait_done();
            check(transfer_done_flag, 1'b1);
            check(8'(togs), 8'd16);
            check(sck_out, r.pol);
            check({sck_oe, mosi_oe, miso_oe}, 3'h6);
            check(far_rx, r.tx);
            check(tx_buffer_empty, 1'b1);
            sfr(1'b0, ADDR_DATA_BUFFER, 8'h00);
            check(sfr_rdata, r.far);
            check(transfer_done_flag, 1'b1);
            clr_done();
        end
        // back-to-back data writes: the second finds the buffer full
        @(posedge clk_sys) sfr_req <= '{1'b1, 1'b0, ADDR_DATA_BUFFER, 8'h11};
        @(posedge clk_sys) sfr_req <= '{1'b1, 1'b0, ADDR_DATA_BUFFER, 8'h22};
        @(posedge clk_sys) sfr_req <= '0;
        tick(1);
        check(write_collision_flag, 1'b1);
        wait_done();
        check(far_rx, 8'h11);
        @(posedge clk_sys) clear_collision <= 1'b1;
        @(posedge clk_sys) clear_collision <= 1'b0;
        tick(1);
        check(write_collision_flag, 1'b0);
        clr_done();
        // slave, both phases: bench plays the external master
        mb = 8'h96;
        for (int ph = 0; ph < 2; ph++)
        begin
            st = ph ? 8'h3c : 8'ha5;
            clr_done();
            @(posedge clk_sys) cfg <= '{1'b1, 1'b0, 1'b0, ph[0]};
            sfr(1'b1, ADDR_DATA_BUFFER, st);
            @(posedge clk_sys) slave_select_n <= 1'b0;
            tick(4);
            check(miso_oe, 1'b1);
            check(miso_out, st[7]);
            for (int i = 7; i >= 0; i--)
            begin
                @(posedge clk_sys) mosi_in <= mb[i];
                tick(5);
                @(posedge clk_sys) sck_in <= 1'b1;
                tick(5);
                @(posedge clk_sys) sck_in <= 1'b0;
                tick(4);
                if (i + ph > 0)
                    check(miso_out, st >> (i + ph - 1) & 8'h01);
            end
            // phase one: still the last bit six cycles after the last edge
            tick(2);
            check(miso_out, ph ? st[0] : mb[7]);
            @(posedge clk_sys) slave_select_n <= 1'b1;
            tick(4);
            check(miso_oe, 1'b0);
            check(miso_out, mb[7]);
            check(transfer_done_flag, 1'b1);
            sfr(1'b0, ADDR_DATA_BUFFER, 8'h00);
            check(sfr_rdata, mb);
        end
        // second reset in mid-run clears the written divider
        @(posedge clk_sys) rst_n <= 1'b0;
        tick(2);
        @(posedge clk_sys) rst_n <= 1'b1;
        check(transfer_done_flag, 1'b0);
        sfr(1'b0, ADDR_CLOCK_DIVIDER, 8'h00);
        check(sfr_rdata, DIVIDER_RESET);
        stop_test();
    end
endmodule // test_spi_clock_data_timing
`default_nettype wire
